/* File: core/ccsh_pkg.sv */
package ccsh_pkg;

  // ---------------------------------------------
  // Synchroniser slots for pin inputs
  // ---------------------------------------------
  localparam int SYNC_W = 6;
  localparam int SY_RECONFIG = 0;
  localparam int SY_CHAIN = 1;
  localparam int SY_DONE = 2;
  localparam int SY_ERR = 3;
  localparam int SY_SCHEME_LO = 4;
  localparam int SY_SCHEME_HI = 5;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h3f;

  // ---------------------------------------------
  // Scheme encodings on scheme_i
  // ---------------------------------------------
  localparam logic [1:0] SCHEME_PASSIVE = 2'h0;
  localparam logic [1:0] SCHEME_SERIAL = 2'h1;
  localparam logic [1:0] SCHEME_PARALLEL = 2'h2;

  // ---------------------------------------------
  // Initialization cycle length in clocks
  // ---------------------------------------------
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] INIT_CYCLES = 4'h8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_WAIT_ENABLE,
    ST_CONFIG,
    ST_RELEASE,
    ST_INIT,
    ST_USER,
    ST_ERROR
  } ccsh_state_type;

  typedef struct packed {
    ccsh_state_type state;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [CNT_W-1:0] init_cnt;
  } ccsh_regs_type;

endpackage : ccsh_pkg

/* File: core/ccsh_config_handshake.sv */
`timescale 1ns/1ns

module ccsh_config_handshake
  import ccsh_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic reconfig_request_n_i,
  input wire logic chain_enable_in_n_i,
  input wire logic [1:0] scheme_i,
  input wire logic chain_option_i,
  input wire logic user_io_out_i,
  input wire logic user_io_oe_i,
  input wire logic load_done_i,
  input wire logic load_error_i,
  input wire logic config_complete_line_i,
  output logic config_complete_line_o,
  output logic config_complete_line_oe_o,
  input wire logic config_error_line_n_i,
  output logic config_error_line_n_o,
  output logic config_error_line_n_oe_o,
  output logic chain_enable_out_n_o,
  output logic chain_enable_out_n_oe_o,
  output logic serial_flash_select_n_o,
  output logic parallel_flash_select_n_o,
  output logic loading_o,
  output logic user_mode_o,
  output logic io_tristate_o
);

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  // States in which an external low on the error line counts as an error
  function automatic logic error_sensed(input ccsh_state_type st);
    error_sensed = (st == ST_CONFIG) || (st == ST_RELEASE) || (st == ST_INIT);
  endfunction : error_sensed

  // States in which the completion line is held low by this device
  function automatic logic holds_done_low(input ccsh_state_type st);
    holds_done_low = (st == ST_RESET) || (st == ST_WAIT_ENABLE) || (st == ST_CONFIG) ||
                     (st == ST_ERROR);
  endfunction : holds_done_low

  ccsh_regs_type regs_r;
  ccsh_regs_type regs_nxt;
  logic reconfig_n_s;
  logic chain_n_s;
  logic done_s;
  logic err_n_s;
  logic [1:0] scheme_s;

  assign reconfig_n_s = regs_r.sync2[SY_RECONFIG];
  assign chain_n_s = regs_r.sync2[SY_CHAIN];
  assign done_s = regs_r.sync2[SY_DONE];
  assign err_n_s = regs_r.sync2[SY_ERR];
  assign scheme_s = regs_r.sync2[SY_SCHEME_HI:SY_SCHEME_LO];

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.sync1 = {scheme_i, config_error_line_n_i, config_complete_line_i,
                      chain_enable_in_n_i, reconfig_request_n_i};
    regs_nxt.sync2 = regs_r.sync1;
    case (regs_r.state)
      ST_RESET: begin
        if (reconfig_n_s) begin
          regs_nxt.state = ST_WAIT_ENABLE;
        end
      end
      ST_WAIT_ENABLE: begin
        // wait for enable
        // Error line must read high first, else our own reset drive looks like an error
        if (!chain_n_s && err_n_s) begin
          regs_nxt.state = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (load_error_i || !err_n_s) begin
          regs_nxt.state = ST_ERROR;
        end else if (chain_n_s) begin
          regs_nxt.state = ST_WAIT_ENABLE;
        end else if (load_done_i) begin
          regs_nxt.state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (!err_n_s) begin
          regs_nxt.state = ST_ERROR;
        end else if (done_s) begin
          regs_nxt.state = ST_INIT;
          regs_nxt.init_cnt = INIT_CYCLES;
        end
      end
      ST_INIT: begin
        if (!err_n_s) begin
          regs_nxt.state = ST_ERROR;
        end else if (regs_r.init_cnt == CNT_ONE) begin
          regs_nxt.state = ST_USER;
          regs_nxt.init_cnt = CNT_ZERO;
        end else begin
          regs_nxt.init_cnt = regs_r.init_cnt - CNT_ONE;
        end
      end
      ST_USER: begin
        regs_nxt.state = ST_USER;
      end
      ST_ERROR: begin
        regs_nxt.state = ST_ERROR;
      end
      default: begin
        regs_nxt.state = ST_RESET;
      end
    endcase
    if (!reconfig_n_s) begin
      regs_nxt.state = ST_RESET;
      regs_nxt.init_cnt = CNT_ZERO;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regs_r <= '{state: ST_RESET, sync1: SYNC_RESET, sync2: SYNC_RESET, init_cnt: CNT_ZERO};
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ---------------------------------------------
  // Pin drivers
  // ---------------------------------------------
  logic in_user;
  logic reading;
  assign in_user = (regs_r.state == ST_USER);
  assign reading = (regs_r.state == ST_CONFIG);

  assign config_complete_line_o = 1'b0;
  assign config_complete_line_oe_o = holds_done_low(regs_r.state);

  // drive error line
  // Reset also holds it low, so a sharing host sees the device is not ready
  assign config_error_line_n_o = 1'b0;
  assign config_error_line_n_oe_o = (regs_r.state == ST_ERROR) || (regs_r.state == ST_RESET);

  always_comb begin
    if (in_user && !chain_option_i) begin
      chain_enable_out_n_o = user_io_out_i;
      chain_enable_out_n_oe_o = user_io_oe_i;
    end else begin
      chain_enable_out_n_o = 1'b0;
      chain_enable_out_n_oe_o = in_user;
    end
  end

  assign serial_flash_select_n_o = !(reading && (scheme_s == SCHEME_SERIAL));
  assign parallel_flash_select_n_o = !(reading && (scheme_s == SCHEME_PARALLEL));

  assign loading_o = reading;
  assign user_mode_o = in_user;
  assign io_tristate_o = !in_user;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_data_in;
    reading && !load_error_i && err_n_s && !chain_n_s && reconfig_n_s && load_done_i;
  endsequence

  sequence s_line_seen_high;
    (regs_r.state == ST_RELEASE) && done_s && err_n_s && reconfig_n_s;
  endsequence

  property p_done_low_in_config;
    reading |-> config_complete_line_oe_o && !config_complete_line_o;
  endproperty
  a_done_low_in_config: assert property (p_done_low_in_config)
    else $error("completion line not held low while configuring");

  property p_release_after_data;
    s_data_in |=> !config_complete_line_oe_o;
  endproperty
  a_release_after_data: assert property (p_release_after_data)
    else $error("completion line not released after data");

  property p_user_needs_high;
    $rose(in_user) |-> $past(done_s, 9) && $past(regs_r.state == ST_RELEASE, 9);
  endproperty
  a_user_needs_high: assert property (p_user_needs_high)
    else $error("user mode entered without completion line high");

  // An error or a reconfiguration request inside the count legally cuts it short
  property p_init_length;
    s_line_seen_high ##1 (err_n_s && reconfig_n_s) [*8] |=> in_user;
  endproperty
  a_init_length: assert property (p_init_length)
    else $error("initialization length wrong");

  property p_init_not_early;
    s_line_seen_high |=> (!in_user) [*8];
  endproperty
  a_init_not_early: assert property (p_init_not_early)
    else $error("user mode entered before initialization ended");

  property p_user_ignores_lines;
    in_user && reconfig_n_s |=> in_user;
  endproperty
  a_user_ignores_lines: assert property (p_user_ignores_lines)
    else $error("user mode left without reconfiguration request");

  property p_no_config_disabled;
    (regs_r.state == ST_WAIT_ENABLE) && chain_n_s |=> !reading;
  endproperty
  a_no_config_disabled: assert property (p_no_config_disabled)
    else $error("configuration started with chain enable high");

  property p_chain_out;
    in_user && chain_option_i |-> chain_enable_out_n_oe_o && !chain_enable_out_n_o;
  endproperty
  a_chain_out: assert property (p_chain_out)
    else $error("chain output not driven low after completion");

  property p_chain_idle;
    !in_user |-> !chain_enable_out_n_oe_o;
  endproperty
  a_chain_idle: assert property (p_chain_idle)
    else $error("chain output driven before completion");

  property p_selects;
    !reading |-> serial_flash_select_n_o && parallel_flash_select_n_o;
  endproperty
  a_selects: assert property (p_selects)
    else $error("memory selected outside configuration");

  property p_select_on;
    reading |-> (serial_flash_select_n_o == (scheme_s != SCHEME_SERIAL)) &&
                (parallel_flash_select_n_o == (scheme_s != SCHEME_PARALLEL));
  endproperty
  a_select_on: assert property (p_select_on)
    else $error("memory select wrong for the scheme");

  property p_reconfig;
    !reconfig_n_s |=> (regs_r.state == ST_RESET) && io_tristate_o;
  endproperty
  a_reconfig: assert property (p_reconfig)
    else $error("reconfiguration request not obeyed");

  property p_error_in;
    error_sensed(regs_r.state) && !err_n_s && reconfig_n_s |=> config_error_line_n_oe_o;
  endproperty
  a_error_in: assert property (p_error_in)
    else $error("external error low not taken during configuration");

endmodule : ccsh_config_handshake

/* File: verification/ccsh_far_side.sv */
`timescale 1ns/1ns
// --------------------------------------
// Far side: pull-ups, peers, memory
// --------------------------------------
module ccsh_far_side (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cpl_oe_i,
  input wire logic err_oe_i,
  input wire logic chain_o_i,
  input wire logic chain_oe_i,
  input wire logic loading_i,
  input wire logic cpl_hold_i,
  input wire logic err_hold_i,
  input wire logic [3:0] delay_i,
  output logic cpl_line_o,
  output logic err_line_o,
  output logic next_en_n_o,
  output logic load_done_o
);
  logic [3:0] cnt_r;
  assign cpl_line_o = !(cpl_oe_i || cpl_hold_i);
  assign err_line_o = !(err_oe_i || err_hold_i);
  assign next_en_n_o = chain_oe_i ? chain_o_i : 1'b1;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 4'h0;
    end else if (!loading_i) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'hf) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign load_done_o = loading_i && (cnt_r == delay_i);
endmodule : ccsh_far_side

/* File: verification/ccsh_config_handshake_tb_top.sv */
`timescale 1ns/1ns
module ccsh_config_handshake_tb_top;
  import ccsh_pkg::*;
  logic clk, rst_n, rcfg_n, chn_n, opt, uo, uoe, lerr, ch, eh;
  logic [1:0] sch;
  logic [3:0] dly;
  logic cpl_l, err_l, nxt_n, ldone, cpl_o, cpl_oe, err_o, err_oe;
  logic co, coe, ssel, psel, ld, um, tri_o;
  logic [5:0] s1, s2;
  int n_mismatch, samples_checked, st, cnt;

  initial begin
    clk = 0;
    forever #50 clk = !clk;
  end

  ccsh_config_handshake ccsh_config_handshake_i (.clock_i(clk), .reset_n_i(rst_n),
    .reconfig_request_n_i(rcfg_n), .chain_enable_in_n_i(chn_n), .scheme_i(sch),
    .chain_option_i(opt), .user_io_out_i(uo), .user_io_oe_i(uoe), .load_done_i(ldone),
    .load_error_i(lerr), .config_complete_line_i(cpl_l), .config_complete_line_o(cpl_o),
    .config_complete_line_oe_o(cpl_oe), .config_error_line_n_i(err_l),
    .config_error_line_n_o(err_o), .config_error_line_n_oe_o(err_oe),
    .chain_enable_out_n_o(co), .chain_enable_out_n_oe_o(coe), .serial_flash_select_n_o(ssel),
    .parallel_flash_select_n_o(psel), .loading_o(ld), .user_mode_o(um), .io_tristate_o(tri_o));

  ccsh_far_side ccsh_far_side_i (.clock_i(clk), .reset_n_i(rst_n), .cpl_oe_i(cpl_oe),
    .err_oe_i(err_oe), .chain_o_i(co), .chain_oe_i(coe), .loading_i(ld), .cpl_hold_i(ch),
    .err_hold_i(eh), .delay_i(dly), .cpl_line_o(cpl_l), .err_line_o(err_l),
    .next_en_n_o(nxt_n), .load_done_o(ldone));

  // --------------------------------------
  // Reference model, pins seen two edges late
  // --------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st = 0;
      cnt = 0;
      s1 = SYNC_RESET;
      s2 = SYNC_RESET;
    end else begin
      if (!s2[SY_RECONFIG]) st = 0;
      else case (st)
        0: st = 1;
        1: if (!s2[SY_CHAIN] && s2[SY_ERR]) st = 2;
        2: if (lerr || !s2[SY_ERR]) st = 6; else if (s2[SY_CHAIN]) st = 1; else if (ldone) st = 3;
        3: if (!s2[SY_ERR]) st = 6; else if (s2[SY_DONE]) st = 4;
        4: if (!s2[SY_ERR]) st = 6; else if (cnt == 1) st = 5;
        default: ;
      endcase
      cnt = (st == 4) ? ((cnt == 0) ? int'(INIT_CYCLES) : cnt - 1) : 0;
      s2 = s1;
      s1 = {sch, err_l, cpl_l, chn_n, rcfg_n};
    end
  end

  task chk(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk

  always @(negedge clk) if (rst_n) begin
    chk("cpl_oe", st < 3 || st == 6, cpl_oe);
    chk("cpl_o", 1'b0, cpl_o);
    chk("err_oe", st == 0 || st == 6, err_oe);
    chk("err_o", 1'b0, err_o);
    chk("user", st == 5, um);
    chk("tristate", st != 5, tri_o);
    chk("loading", st == 2, ld);
    chk("ser_sel", !(st == 2 && s2[5:4] == SCHEME_SERIAL), ssel);
    chk("par_sel", !(st == 2 && s2[5:4] == SCHEME_PARALLEL), psel);
    chk("chain_oe", st == 5 && (opt || uoe), coe);
    if (coe === 1'b1) chk("chain_o", opt ? 1'b0 : uo, co);
    chk("next_en", (st == 5 && (opt || uoe)) ? (opt ? 1'b0 : uo) : 1'b1, nxt_n);
  end

  // --------------------------------------
  // Stimulus
  // --------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic await(ref logic sg, input logic v);
    int i;
    for (i = 0; i < 90 && sg !== v; i++) @(posedge clk);
    if (sg !== v) begin
      n_mismatch++;
      $display("CHECK FAILED wait expected %b seen %b", v, sg);
    end
  endtask : await

  task automatic run(input int k, input int s);
    rcfg_n <= 1'b0;
    sch <= 2'(s);
    opt <= 1'($urandom);
    uo <= 1'($urandom);
    uoe <= 1'($urandom);
    dly <= (k == 1) ? 4'he : 4'($urandom_range(12, 1));
    chn_n <= (k == 1);
    ch <= (k == 3);
    cyc(6);
    rcfg_n <= 1'b1;
    if (k == 1) begin
      cyc(12);
      chn_n <= 1'b0;
      await(ld, 1'b1);
      cyc(3);
      chn_n <= 1'b1;
      cyc(6);
      chn_n <= 1'b0;
    end
    await(ld, 1'b1);
    if (k == 2) begin
      lerr <= 1'b1;
      cyc(1);
      lerr <= 1'b0;
      cyc(6);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
    end else if (k == 4) begin
      await(cpl_oe, 1'b0);
      cyc(5);
      eh <= 1'b1;
      cyc(3);
      eh <= 1'b0;
      cyc(4);
    end else begin
      if (k == 3) cyc(20);
      ch <= 1'b0;
      await(um, 1'b1);
      ch <= 1'b1;
      eh <= 1'b1;
      cyc(4);
      ch <= 1'b0;
      eh <= 1'b0;
      cyc(4);
    end
  endtask : run

  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    void'($urandom(63423));
    {rst_n, chn_n, sch, opt, uo, uoe, lerr, ch, eh} = '0;
    rcfg_n = 1'b1;
    dly = 4'h1;
    cyc(20);
    rst_n <= 1'b1;
    for (int j = 0; j < 15; j++) run(j % 5, j % 3);
    cyc(10);
    report_and_stop();
  end
endmodule : ccsh_config_handshake_tb_top
